// file: logic/rlc_top.sv
`timescale 1ns/100ps
// Behaviour
// - single repeat runs N plus one times
// - only single-cycle instructions repeat
// - computed count copied into counter first
// - sixteen-bit counts give up to 65536 runs
// - two nested block levels, own registers
// - native mode records active loops on call
// - native picks inner level if outer active
// - compat mode uses outer level only
// - compat start sets flag, end clears it
// - software clearing flag stops compat loop
// - one status write updates flag and mode
// - block counters hold further passes, 16 bits
// - each level keeps 24-bit start, end
module rlc_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rpt_start_i,
  input wire logic rpt_use_csr_i,
  input wire logic rpt_single_i,
  input wire logic [15:0] rpt_count_i,
  input wire logic rpt_exec_i,
  output logic rpt_active_o,
  output logic rpt_reject_o,
  input wire logic blk_start_i,
  input wire logic [23:0] blk_sa_i,
  input wire logic [23:0] blk_ea_i,
  input wire logic pc_valid_i,
  input wire logic [23:0] pc_i,
  input wire logic ctx_save_i,
  output logic branch_o,
  output logic [23:0] branch_addr_o,
  output logic [1:0] loop_active_o,
  output logic [1:0] loop_ctx_o,
  output logic legacy_compat_mode_o
);
  // ==========================================================================
  // Bus decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr_en;
  logic [15:0] wd16;
  logic [23:0] wd24;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign wd16 = pwdata_i[15:0];
  assign wd24 = pwdata_i[23:0];
  assign pready_o = 1'b1;

  logic [15:0] single_repeat_counter_q;
  logic [15:0] computed_repeat_count_q;
  logic [15:0] outer_loop_counter_q;
  logic [15:0] inner_loop_counter_q;
  logic [15:0] inner_count_save_q;
  logic [23:0] outer_loop_start_addr_q;
  logic [23:0] outer_loop_end_addr_q;
  logic [23:0] inner_loop_start_addr_q;
  logic [23:0] inner_loop_end_addr_q;
  logic loop_active_flag_q;
  logic legacy_compat_mode_q;
  logic rpt_active_q;
  logic rpt_reject_q;
  logic [1:0] act_q;
  logic [1:0] ctx_q;
  logic branch_q;
  logic [23:0] branch_addr_q;

  logic mapped;
  always_comb begin
    mapped = hit(paddr_i, rlc_pkg::OFF_STATUS1) || hit(paddr_i, rlc_pkg::OFF_SRPT_CNT)
      || hit(paddr_i, rlc_pkg::OFF_CSR) || hit(paddr_i, rlc_pkg::OFF_OUT_CNT)
      || hit(paddr_i, rlc_pkg::OFF_OUT_SA) || hit(paddr_i, rlc_pkg::OFF_OUT_EA)
      || hit(paddr_i, rlc_pkg::OFF_IN_CNT) || hit(paddr_i, rlc_pkg::OFF_IN_SAVE)
      || hit(paddr_i, rlc_pkg::OFF_IN_SA) || hit(paddr_i, rlc_pkg::OFF_IN_EA)
      || hit(paddr_i, rlc_pkg::OFF_LOOP_STATE);
  end
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_comb begin
    prdata_o = rlc_pkg::RD_ZERO;
    if (hit(paddr_i, rlc_pkg::OFF_STATUS1)) begin
      prdata_o[rlc_pkg::BIT_LAF] = loop_active_flag_q;
      prdata_o[rlc_pkg::BIT_COMPAT] = legacy_compat_mode_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_SRPT_CNT)) begin
      prdata_o[15:0] = single_repeat_counter_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_CSR)) begin
      prdata_o[15:0] = computed_repeat_count_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_OUT_CNT)) begin
      prdata_o[15:0] = outer_loop_counter_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_OUT_SA)) begin
      prdata_o[23:0] = outer_loop_start_addr_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_OUT_EA)) begin
      prdata_o[23:0] = outer_loop_end_addr_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_IN_CNT)) begin
      prdata_o[15:0] = inner_loop_counter_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_IN_SAVE)) begin
      prdata_o[15:0] = inner_count_save_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_IN_SA)) begin
      prdata_o[23:0] = inner_loop_start_addr_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_IN_EA)) begin
      prdata_o[23:0] = inner_loop_end_addr_q;
    end else if (hit(paddr_i, rlc_pkg::OFF_LOOP_STATE)) begin
      prdata_o[rlc_pkg::BIT_OUT_ACT] = act_q[0];
      prdata_o[rlc_pkg::BIT_IN_ACT] = act_q[1];
      prdata_o[rlc_pkg::BIT_SRPT_ACT] = rpt_active_q;
      prdata_o[rlc_pkg::BIT_CTX_LO +: 2] = ctx_q;
    end
  end

  logic wr_status;
  assign wr_status = wr_en && hit(paddr_i, rlc_pkg::OFF_STATUS1);

  // ==========================================================================
  // Single repeat
  logic rpt_go;
  assign rpt_go = rpt_start_i && rpt_single_i;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      computed_repeat_count_q <= rlc_pkg::CNT_RST;
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_CSR)) begin
      computed_repeat_count_q <= wd16;
    end
  end

  // Hardware updates win over a colliding bus write so a running repeat stays exact
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      single_repeat_counter_q <= rlc_pkg::CNT_RST;
      rpt_active_q <= 1'b0;
    end else if (rpt_go) begin
      single_repeat_counter_q <= rpt_use_csr_i ? computed_repeat_count_q : rpt_count_i;
      rpt_active_q <= 1'b1;
    end else if (rpt_active_q && rpt_exec_i) begin
      if (single_repeat_counter_q == rlc_pkg::CNT_RST) begin
        rpt_active_q <= 1'b0;
      end else begin
        single_repeat_counter_q <= single_repeat_counter_q - 16'h0001;
      end
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_SRPT_CNT)) begin
      single_repeat_counter_q <= wd16;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rpt_reject_q <= 1'b0;
    end else begin
      rpt_reject_q <= rpt_start_i && !rpt_single_i;
    end
  end

  // ==========================================================================
  // Block repeat level select and end detection
  logic use_inner;
  logic end_in;
  logic end_out;
  assign use_inner = !legacy_compat_mode_q && act_q[0];
  assign end_in = pc_valid_i && act_q[1] && (pc_i == inner_loop_end_addr_q);
  assign end_out = pc_valid_i && act_q[0] && !end_in && (pc_i == outer_loop_end_addr_q);

  logic start_in;
  logic start_out;
  assign start_in = blk_start_i && use_inner;
  assign start_out = blk_start_i && !use_inner;

  logic out_done;
  logic in_done;
  assign out_done = end_out && (outer_loop_counter_q == rlc_pkg::CNT_RST);
  assign in_done = end_in && (inner_loop_counter_q == rlc_pkg::CNT_RST);

  // Bus writes to the addresses collide only with the start strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      outer_loop_start_addr_q <= rlc_pkg::ADDR_RST;
      outer_loop_end_addr_q <= rlc_pkg::ADDR_RST;
    end else if (start_out) begin
      outer_loop_start_addr_q <= blk_sa_i;
      outer_loop_end_addr_q <= blk_ea_i;
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_OUT_SA)) begin
      outer_loop_start_addr_q <= wd24;
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_OUT_EA)) begin
      outer_loop_end_addr_q <= wd24;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      inner_loop_start_addr_q <= rlc_pkg::ADDR_RST;
      inner_loop_end_addr_q <= rlc_pkg::ADDR_RST;
    end else if (start_in) begin
      inner_loop_start_addr_q <= blk_sa_i;
      inner_loop_end_addr_q <= blk_ea_i;
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_IN_SA)) begin
      inner_loop_start_addr_q <= wd24;
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_IN_EA)) begin
      inner_loop_end_addr_q <= wd24;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      outer_loop_counter_q <= rlc_pkg::CNT_RST;
    end else if (end_out && !out_done) begin
      outer_loop_counter_q <= outer_loop_counter_q - 16'h0001;
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_OUT_CNT)) begin
      outer_loop_counter_q <= wd16;
    end
  end

  // The save copy lets software set the inner count once, outside the outer body
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      inner_loop_counter_q <= rlc_pkg::CNT_RST;
      inner_count_save_q <= rlc_pkg::CNT_RST;
    end else if (start_in) begin
      inner_loop_counter_q <= inner_count_save_q;
    end else if (end_in && !in_done) begin
      inner_loop_counter_q <= inner_loop_counter_q - 16'h0001;
    end else if (wr_en && hit(paddr_i, rlc_pkg::OFF_IN_CNT)) begin
      inner_loop_counter_q <= wd16;
      inner_count_save_q <= wd16;
    end
  end

  // ==========================================================================
  // Loop activity, flag and mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_q[1] <= 1'b0;
    end else if (start_in) begin
      act_q[1] <= 1'b1;
    end else if (in_done || legacy_compat_mode_q) begin
      act_q[1] <= 1'b0;
    end
  end

  // A start in the same cycle as a software clear wins: the new loop stays live
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_q[0] <= 1'b0;
      loop_active_flag_q <= 1'b0;
    end else if (start_out) begin
      act_q[0] <= 1'b1;
      loop_active_flag_q <= legacy_compat_mode_q ? 1'b1 : loop_active_flag_q;
    end else if (out_done) begin
      act_q[0] <= 1'b0;
      loop_active_flag_q <= 1'b0;
    end else if (wr_status) begin
      loop_active_flag_q <= pwdata_i[rlc_pkg::BIT_LAF];
      if (legacy_compat_mode_q && !pwdata_i[rlc_pkg::BIT_LAF]) begin
        act_q[0] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      legacy_compat_mode_q <= rlc_pkg::RST_COMPAT;
    end else if (wr_status) begin
      legacy_compat_mode_q <= pwdata_i[rlc_pkg::BIT_COMPAT];
    end
  end

  // Snapshot of live levels on a call or interrupt, native mode only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctx_q <= 2'h0;
    end else if (ctx_save_i && !legacy_compat_mode_q) begin
      ctx_q <= act_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      branch_q <= 1'b0;
      branch_addr_q <= rlc_pkg::ADDR_RST;
    end else begin
      branch_q <= (end_in && !in_done) || (end_out && !out_done);
      if (end_in) begin
        branch_addr_q <= inner_loop_start_addr_q;
      end else if (end_out) begin
        branch_addr_q <= outer_loop_start_addr_q;
      end
    end
  end

  assign rpt_active_o = rpt_active_q;
  assign rpt_reject_o = rpt_reject_q;
  assign loop_active_o = act_q;
  assign loop_ctx_o = ctx_q;
  assign branch_o = branch_q;
  assign branch_addr_o = branch_addr_q;
  assign legacy_compat_mode_o = legacy_compat_mode_q;

  // ==========================================================================
  // Assertions
  a_rpt_load_csr: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rpt_go && rpt_use_csr_i |=> single_repeat_counter_q == $past(computed_repeat_count_q))
    else $error("repeat count not copied from computed count");
  a_rpt_multi_refused: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rpt_start_i && !rpt_single_i && !rpt_active_q |=> !rpt_active_q && rpt_reject_q)
    else $error("multi-cycle instruction started a repeat");
  a_rpt_last_exec: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rpt_active_q && rpt_exec_i && !rpt_go && single_repeat_counter_q == 16'h0000
    |=> !rpt_active_q)
    else $error("single repeat ran past its count");
  a_rpt_decrement: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rpt_active_q && rpt_exec_i && !rpt_go && single_repeat_counter_q != 16'h0000
    |=> rpt_active_q && single_repeat_counter_q == $past(single_repeat_counter_q) - 16'h0001)
    else $error("single repeat counter did not step by one");
  a_level_inner_pick: assert property (@(posedge clk_i) disable iff (!resetn_i)
    blk_start_i && !legacy_compat_mode_q && act_q[0]
    |=> act_q[1] && inner_loop_start_addr_q == $past(blk_sa_i))
    else $error("native nested start did not use inner level");
  a_compat_outer_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
    blk_start_i && legacy_compat_mode_q |=> !act_q[1] && act_q[0] && loop_active_flag_q)
    else $error("compat start used inner level or left flag clear");
  a_flag_clear_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
    out_done && !blk_start_i |=> !loop_active_flag_q && !act_q[0])
    else $error("flag not cleared at outer loop end");
  a_flag_stop_loop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_status && legacy_compat_mode_q && !pwdata_i[rlc_pkg::BIT_LAF] && !start_out && !out_done
    |=> !act_q[0])
    else $error("clearing flag did not stop compat loop");
  a_status_both: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_status && !start_out && !out_done
    |=> loop_active_flag_q == $past(pwdata_i[rlc_pkg::BIT_LAF])
    && legacy_compat_mode_q == $past(pwdata_i[rlc_pkg::BIT_COMPAT]))
    else $error("status write did not update both bits");
  a_inner_reload: assert property (@(posedge clk_i) disable iff (!resetn_i)
    start_in |=> inner_loop_counter_q == $past(inner_count_save_q)
    && inner_count_save_q == $past(inner_count_save_q))
    else $error("inner counter not reloaded from save copy");
  a_branch_back: assert property (@(posedge clk_i) disable iff (!resetn_i)
    end_out && !out_done |=> branch_o && branch_addr_o == $past(outer_loop_start_addr_q)
    ##1 !branch_o || $past(end_in || end_out))
    else $error("outer loop end did not branch to start");
  a_ctx_record: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ctx_save_i && !legacy_compat_mode_q |=> loop_ctx_o == $past(act_q))
    else $error("active loops not recorded on call");
endmodule : rlc_top

// file: logic/rlc_pkg.sv
package rlc_pkg;
  // ==========================================================================
  // Widths
  localparam int CNT_W = 16;
  localparam int ADDR_W = 24;
  localparam int PADDR_W = 12;
  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_STATUS1 = 12'h000;
  localparam logic [11:0] OFF_SRPT_CNT = 12'h004;
  localparam logic [11:0] OFF_CSR = 12'h008;
  localparam logic [11:0] OFF_OUT_CNT = 12'h00C;
  localparam logic [11:0] OFF_OUT_SA = 12'h010;
  localparam logic [11:0] OFF_OUT_EA = 12'h014;
  localparam logic [11:0] OFF_IN_CNT = 12'h018;
  localparam logic [11:0] OFF_IN_SAVE = 12'h01C;
  localparam logic [11:0] OFF_IN_SA = 12'h020;
  localparam logic [11:0] OFF_IN_EA = 12'h024;
  localparam logic [11:0] OFF_LOOP_STATE = 12'h028;
  // ==========================================================================
  // Field positions in status_word_one and the loop state word
  localparam int BIT_LAF = 15;
  localparam int BIT_COMPAT = 5;
  localparam int BIT_OUT_ACT = 0;
  localparam int BIT_IN_ACT = 1;
  localparam int BIT_SRPT_ACT = 2;
  localparam int BIT_CTX_LO = 4;
  // ==========================================================================
  // Reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic RST_COMPAT = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage : rlc_pkg

// file: test/rlc_cpu_model.sv
`timescale 1ns/100ps
module rlc_cpu_model (
  input wire logic clk_i,
  output logic rpt_start_o,
  output logic rpt_use_csr_o,
  output logic rpt_single_o,
  output logic [15:0] rpt_count_o,
  output logic rpt_exec_o,
  output logic blk_start_o,
  output logic [23:0] blk_sa_o,
  output logic [23:0] blk_ea_o,
  output logic pc_valid_o,
  output logic [23:0] pc_o,
  output logic ctx_save_o
);
  // ==========
  // Idle state
  initial begin
    rpt_start_o = 1'h0;
    rpt_use_csr_o = 1'h0;
    rpt_single_o = 1'h0;
    rpt_count_o = 16'h0000;
    rpt_exec_o = 1'h0;
    blk_start_o = 1'h0;
    blk_sa_o = 24'h000000;
    blk_ea_o = 24'h000000;
    pc_valid_o = 1'h0;
    pc_o = 24'h000000;
    ctx_save_o = 1'h0;
  end
  // ==========
  // Decode and flow events; qualifiers turn to junk once the strobe drops
  task automatic rpt(input logic computed_repeat_count, input logic single, input logic [15:0] n);
    @(posedge clk_i);
    rpt_start_o <= 1'h1;
    rpt_use_csr_o <= computed_repeat_count;
    rpt_single_o <= single;
    rpt_count_o <= n;
    @(posedge clk_i);
    rpt_start_o <= 1'h0;
    rpt_use_csr_o <= ~computed_repeat_count;
    rpt_single_o <= ~single;
    rpt_count_o <= ~n;
  endtask : rpt
  // Gap lets the caller model a slow pipeline between executions
  task automatic exec(input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    rpt_exec_o <= 1'h1;
    @(posedge clk_i);
    rpt_exec_o <= 1'h0;
  endtask : exec
  task automatic blk(input logic [23:0] sa, input logic [23:0] ea);
    @(posedge clk_i);
    blk_start_o <= 1'h1;
    blk_sa_o <= sa;
    blk_ea_o <= ea;
    @(posedge clk_i);
    blk_start_o <= 1'h0;
    blk_sa_o <= ~sa;
    blk_ea_o <= ~ea;
  endtask : blk
  task automatic step(input logic [23:0] a);
    @(posedge clk_i);
    pc_valid_o <= 1'h1;
    pc_o <= a;
    @(posedge clk_i);
    pc_valid_o <= 1'h0;
    pc_o <= ~a;
  endtask : step
  task automatic ctx();
    @(posedge clk_i);
    ctx_save_o <= 1'h1;
    @(posedge clk_i);
    ctx_save_o <= 1'h0;
  endtask : ctx
endmodule : rlc_cpu_model

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'h0;
  logic resetn_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rpt_active_o, rpt_reject_o, branch_o, legacy_compat_mode_o;
  logic rpt_start_i, rpt_use_csr_i, rpt_single_i, rpt_exec_i, blk_start_i;
  logic pc_valid_i, ctx_save_i;
  logic [15:0] rpt_count_i;
  logic [15:0] n;
  logic [23:0] blk_sa_i, blk_ea_i, pc_i, branch_addr_o;
  logic [1:0] loop_active_o, loop_ctx_o;
  logic [32:0] rd_q[$];
  logic [23:0] br_q[$];
  logic [32:0] exp_v;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'hF130753F;

  always #10 clk_i = ~clk_i;

  rlc_cpu_model cpu (.clk_i, .rpt_start_o(rpt_start_i), .rpt_use_csr_o(rpt_use_csr_i),
    .rpt_single_o(rpt_single_i), .rpt_count_o(rpt_count_i), .rpt_exec_o(rpt_exec_i),
    .blk_start_o(blk_start_i), .blk_sa_o(blk_sa_i), .blk_ea_o(blk_ea_i),
    .pc_valid_o(pc_valid_i), .pc_o(pc_i), .ctx_save_o(ctx_save_i));
  rlc_top dut (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .rpt_start_i, .rpt_use_csr_i, .rpt_single_i,
    .rpt_count_i, .rpt_exec_i, .rpt_active_o, .rpt_reject_o, .blk_start_i, .blk_sa_i,
    .blk_ea_i, .pc_valid_i, .pc_i, .ctx_save_i, .branch_o, .branch_addr_o,
    .loop_active_o, .loop_ctx_o, .legacy_compat_mode_o);

  // ==========
  // Helpers
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Read expectations are queued before the access edge, the monitor pops them
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    if (!w) rd_q.push_back(e);
    @(posedge clk_i);
    while (pready_o !== 1'h1) @(posedge clk_i);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : apb
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // ==========
  // Output monitor
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'h1 && !pwrite_i) begin
      exp_v = rd_q.size() ? rd_q.pop_front() : 'x;
      chk("apb read", exp_v, {pslverr_o, prdata_o});
    end
    if (branch_o === 1'h1) begin
      exp_v = br_q.size() ? {9'h000, br_q.pop_front()} : 'x;
      chk("branch target", exp_v, {9'h000, branch_addr_o});
    end
  end

  initial begin
    #(20 * 20000);
    errors++;
    $display("watchdog expired");
    end_of_test();
  end

  // ==========
  // Scenarios
  initial begin
    resetn_i <= 1'h0;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    pwrite_i <= 1'h0;
    paddr_i <= 12'h000;
    pwdata_i <= 32'h00000000;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'h1;
    for (int a = 0; a <= 40; a += 4) apb(1'h0, a[11:0], 32'h0, 33'h0);
    apb(1'h0, 12'h0FC, 32'h0, {1'h1, 32'h0});
    $display("test reset done");

    apb(1'h1, rlc_pkg::OFF_CSR, 32'h0000FFFF, 33'h0);
    cpu.rpt(1'h1, 1'h1, 16'h1234);
    apb(1'h0, rlc_pkg::OFF_SRPT_CNT, 32'h0, 33'h0FFFF);
    cpu.exec(0);
    apb(1'h0, rlc_pkg::OFF_SRPT_CNT, 32'h0, 33'h0FFFE);
    n = 16'($random(seed)) & 16'h0007;
    cpu.rpt(1'h0, 1'h1, n);
    for (int i = 0; i <= int'(n); i++) begin
      @(negedge clk_i);
      chk("repeat running", 33'h1, rpt_active_o);
      cpu.exec($random(seed) & 32'h3);
    end
    @(negedge clk_i);
    chk("repeat ended", 33'h0, rpt_active_o);
    cpu.rpt(1'h0, 1'h0, 16'h0005);
    @(negedge clk_i);
    chk("multi-cycle refused", 33'h1, rpt_reject_o);
    chk("refused idle", 33'h0, rpt_active_o);
    $display("test single repeat done");

    apb(1'h1, rlc_pkg::OFF_OUT_CNT, 32'h1, 33'h0);
    cpu.blk(24'h000100, 24'h000104);
    @(negedge clk_i);
    chk("outer level", 33'h1, loop_active_o);
    apb(1'h0, rlc_pkg::OFF_OUT_SA, 32'h0, 33'h100);
    apb(1'h0, rlc_pkg::OFF_OUT_EA, 32'h0, 33'h104);
    apb(1'h1, rlc_pkg::OFF_IN_CNT, 32'h2, 33'h0);
    apb(1'h0, rlc_pkg::OFF_IN_SAVE, 32'h0, 33'h2);
    for (int j = 0; j < 2; j++) begin
      cpu.blk(24'h000200, 24'h000203);
      @(negedge clk_i);
      chk("nested levels", 33'h3, loop_active_o);
      apb(1'h0, rlc_pkg::OFF_IN_CNT, 32'h0, 33'h2);
      cpu.ctx();
      @(negedge clk_i);
      chk("loop record", 33'h3, loop_ctx_o);
      for (int i = 0; i < 3; i++) begin
        if (i < 2) br_q.push_back(24'h000200);
        cpu.step(24'h000203);
      end
      @(negedge clk_i);
      chk("inner finished", 33'h1, loop_active_o);
    end
    cpu.step(24'h000101);
    br_q.push_back(24'h000100);
    cpu.step(24'h000104);
    cpu.step(24'h000104);
    @(negedge clk_i);
    chk("outer finished", 33'h0, loop_active_o);
    $display("test native blocks done");

    apb(1'h1, rlc_pkg::OFF_STATUS1, 32'h00000020, 33'h0);
    @(negedge clk_i);
    chk("compat set", 33'h1, legacy_compat_mode_o);
    apb(1'h1, rlc_pkg::OFF_OUT_CNT, 32'h3, 33'h0);
    cpu.blk(24'h000300, 24'h000302);
    @(negedge clk_i);
    chk("outer only", 33'h1, loop_active_o);
    apb(1'h0, rlc_pkg::OFF_STATUS1, 32'h0, 33'h8020);
    apb(1'h0, rlc_pkg::OFF_IN_SA, 32'h0, 33'h200);
    br_q.push_back(24'h000300);
    cpu.step(24'h000302);
    // Flag and mode cleared in one write, the safe way out of compat mode
    apb(1'h1, rlc_pkg::OFF_STATUS1, 32'h0, 33'h0);
    @(negedge clk_i);
    chk("loop stopped", 33'h0, loop_active_o);
    chk("native again", 33'h0, legacy_compat_mode_o);
    apb(1'h0, rlc_pkg::OFF_STATUS1, 32'h0, 33'h0);
    apb(1'h1, rlc_pkg::OFF_STATUS1, 32'h00000020, 33'h0);
    apb(1'h1, rlc_pkg::OFF_OUT_CNT, 32'h0, 33'h0);
    cpu.blk(24'h000500, 24'h000501);
    cpu.step(24'h000501);
    @(negedge clk_i);
    chk("compat fell", 33'h0, loop_active_o);
    apb(1'h0, rlc_pkg::OFF_STATUS1, 32'h0, 33'h20);
    $display("test compat blocks done");

    repeat (3) @(posedge clk_i);
    chk("notes left", 33'h0, 33'(rd_q.size() + br_q.size()));
    end_of_test();
  end
endmodule : tb_top
